// ---- rtl/pmsr_top.sv ----
// Purpose: slew step, linear regulator set-point and sequencer delay registers
// Assumes: register port is the sub-address side of the two-wire interface
// Notes:   one clock, synchronous active-low reset
//
// How it works
// - slew code 0 gives 160 us per step, halving per code to 2.5 us.
// - slew code 7 applies a new buck set-point at once, no wait.
// - step timing only moves the two buck rail codes.
// - go bit starts both rails moving; hardware clears it when done.
// - six-bit regulator set-point, 0.9 V to 3.4 V, resets to 1fh.
// - each accepted set-point write blanks voltage monitoring for 5 ms.
// - set-point and delay registers take writes only while unlocked.
// - each delay bit picks a 2 ms gap when 0, 5 ms when 1.
// - low delay register bit n sets the gap after strobe n+1.
// - low delay register at 20h, resets to 00h, all gaps 2 ms.
// - multiplier bit stretches every gap tenfold during power-down only.
// - bit 0 of the high delay register sets the gap after strobe nine.
`timescale 1ns/10ps
`include "pmsr_regs.svh"

module pmsr_top #(
   parameter logic [12:0] STEP_UNIT_CYC = 13'(`PMSR_SLEW_UNIT_CYC),
   parameter logic [5:0] US_CYC = 6'(`PMSR_US_CYC)
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire pmsr_pkg::pmsr_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic reg_wr_refused,
   input wire logic pw_unlocked,
   input wire pmsr_pkg::pmsr_buck_t buck_target,
   input wire logic buck_target_update,
   output pmsr_pkg::pmsr_buck_t buck_code,
   output logic buck_busy,
   output logic [5:0] linear_reg_setpoint,
   output logic linear_reg_monitor_blank,
   input wire logic seq_gap_start,
   input wire logic [3:0] seq_gap_index,
   input wire logic seq_powerdown,
   output logic seq_gap_busy,
   output logic seq_gap_done
);
   import pmsr_pkg::*;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [12:0] step_cycles(input logic [2:0] code);
      logic [2:0] shift;
      shift = `PMSR_SLEW_FASTEST - code;
      step_cycles = STEP_UNIT_CYC << shift;
   endfunction

   function automatic logic [15:0] gap_us(input logic sel, input logic stretch);
      logic [15:0] base;
      base = sel ? 16'(`PMSR_GAP_LONG_MS * `PMSR_MS_US)
                 : 16'(`PMSR_GAP_SHORT_MS * `PMSR_MS_US);
      gap_us = stretch ? 16'(base * `PMSR_PD_FACTOR) : base;
   endfunction

   function automatic logic [5:0] step_toward(input logic [5:0] cur, input logic [5:0] tgt);
      if (cur < tgt) begin
         step_toward = cur + 6'h01;
      end else if (cur > tgt) begin
         step_toward = cur - 6'h01;
      end else begin
         step_toward = cur;
      end
   endfunction

   pmsr_state_t st_reg;
   pmsr_state_t st_next;

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic wr_slew;
      logic wr_lock;
      logic wr_ok;
      logic start;
      logic gap_sel;
      wr_slew = 1'b0;
      wr_lock = 1'b0;
      wr_ok = 1'b0;
      start = 1'b0;
      gap_sel = 1'b0;
      st_next = st_reg;
      st_next.rvalid = 1'b0;
      st_next.wr_refused = 1'b0;
      st_next.gap_done = 1'b0;

      // register writes
      wr_slew = reg_req.wr && reg_req.addr == `PMSR_ADDR_SLEW;
      wr_lock = reg_req.wr && (reg_req.addr == `PMSR_ADDR_LDO ||
                reg_req.addr == `PMSR_ADDR_SEQ_LO || reg_req.addr == `PMSR_ADDR_SEQ_HI);
      wr_ok = wr_lock && pw_unlocked;
      st_next.wr_refused = wr_lock && !pw_unlocked;
      if (wr_slew) begin
         st_next.trigger_bypass = reg_req.wdata[`PMSR_BYPASS_BIT];
         st_next.slew = reg_req.wdata[2:0];
      end
      if (wr_ok) begin
         case (reg_req.addr)
            `PMSR_ADDR_LDO: st_next.linear_reg_setpoint = reg_req.wdata[5:0];
            `PMSR_ADDR_SEQ_LO: st_next.seq_lo = reg_req.wdata;
            `PMSR_ADDR_SEQ_HI: begin
               st_next.powerdown_gap_multiplier = reg_req.wdata[`PMSR_FACTOR_BIT];
               st_next.gap_nine_select = reg_req.wdata[`PMSR_GAP9_BIT];
            end
            default: st_next.seq_lo = st_reg.seq_lo;
         endcase
      end

      // register reads, reserved bits zero
      if (reg_req.rd) begin
         st_next.rvalid = 1'b1;
         case (reg_req.addr)
            `PMSR_ADDR_SLEW: st_next.rdata = {st_reg.go, st_reg.trigger_bypass, 3'h0, st_reg.slew};
            `PMSR_ADDR_LDO: st_next.rdata = {2'h0, st_reg.linear_reg_setpoint};
            `PMSR_ADDR_SEQ_LO: st_next.rdata = st_reg.seq_lo;
            `PMSR_ADDR_SEQ_HI: st_next.rdata = {st_reg.powerdown_gap_multiplier, 6'h00,
                                                st_reg.gap_nine_select};
            default: st_next.rdata = 8'h00;
         endcase
      end

      // microsecond timebase
      st_next.us_tick = 1'b0;
      if (st_reg.us_cnt == US_CYC - 6'h01) begin
         st_next.us_cnt = 6'h00;
         st_next.us_tick = 1'b1;
      end else begin
         st_next.us_cnt = st_reg.us_cnt + 6'h01;
      end

      // monitor blanking, restarted by every accepted set-point write
      if (wr_ok && reg_req.addr == `PMSR_ADDR_LDO) begin
         st_next.blank = 1'b1;
         st_next.blank_cnt = 16'(`PMSR_BLANK_MS * `PMSR_MS_US);
      end else if (st_reg.blank && st_reg.us_tick) begin
         if (st_reg.blank_cnt <= 16'h0001) begin
            st_next.blank = 1'b0;
            st_next.blank_cnt = 16'h0000;
         end else begin
            st_next.blank_cnt = st_reg.blank_cnt - 16'h0001;
         end
      end

      // buck rail slew engine
      start = (wr_slew && reg_req.wdata[`PMSR_GO_BIT]) ||
              (st_reg.trigger_bypass && buck_target_update);
      case (st_reg.sl_state)
         SL_IDLE: begin
            if (start) begin
               st_next.go = 1'b1;
               st_next.sl_state = SL_MOVE;
               st_next.step_cnt = step_cycles(st_next.slew);
            end
         end
         SL_MOVE: begin
            if (st_reg.slew == `PMSR_SLEW_IMMEDIATE) begin
               st_next.buck = buck_target;
               // stay in move on a fresh go, else busy would hang in idle
               st_next.sl_state = start ? SL_MOVE : SL_IDLE;
               st_next.go = start;
            end else if (st_reg.buck == buck_target) begin
               // a go written in the ending cycle wins over the clear
               st_next.go = start;
               st_next.sl_state = start ? SL_MOVE : SL_IDLE;
               st_next.step_cnt = step_cycles(st_reg.slew);
            end else if (st_reg.step_cnt <= 13'h0001) begin
               st_next.buck.one = step_toward(st_reg.buck.one, buck_target.one);
               st_next.buck.two = step_toward(st_reg.buck.two, buck_target.two);
               st_next.step_cnt = step_cycles(st_reg.slew);
            end else begin
               st_next.step_cnt = st_reg.step_cnt - 13'h0001;
            end
         end
         default: begin
            st_next.sl_state = SL_IDLE;
            st_next.go = 1'b0;
         end
      endcase

      // sequencer inter-strobe gap timer
      case (st_reg.sq_state)
         SQ_IDLE: begin
            if (seq_gap_start) begin
               if (seq_gap_index == 4'h9) begin
                  gap_sel = st_reg.gap_nine_select;
               end else if (seq_gap_index >= 4'h1 && seq_gap_index <= 4'h8) begin
                  gap_sel = st_reg.seq_lo[3'(seq_gap_index - 4'h1)];
               end
               st_next.gap_cnt = gap_us(gap_sel,
                                        seq_powerdown && st_reg.powerdown_gap_multiplier);
               st_next.sq_state = SQ_WAIT;
            end
         end
         SQ_WAIT: begin
            if (st_reg.us_tick) begin
               if (st_reg.gap_cnt <= 16'h0001) begin
                  st_next.gap_cnt = 16'h0000;
                  st_next.gap_done = 1'b1;
                  st_next.sq_state = SQ_IDLE;
               end else begin
                  st_next.gap_cnt = st_reg.gap_cnt - 16'h0001;
               end
            end
         end
         default: st_next.sq_state = SQ_IDLE;
      endcase
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         st_reg <= '0;
         st_reg.slew <= `PMSR_SLEW_RST;
         st_reg.linear_reg_setpoint <= `PMSR_LDO_RST;
         st_reg.seq_lo <= `PMSR_SEQ_LO_RST;
         st_reg.gap_nine_select <= `PMSR_SEQ_HI_RST;
         st_reg.sl_state <= SL_IDLE;
         st_reg.sq_state <= SQ_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------------
   // outputs, all from flops
   // ----------------------------------------------------------------------
   assign reg_rdata = st_reg.rdata;
   assign reg_rvalid = st_reg.rvalid;
   assign reg_wr_refused = st_reg.wr_refused;
   assign buck_code = st_reg.buck;
   assign buck_busy = st_reg.go;
   assign linear_reg_setpoint = st_reg.linear_reg_setpoint;
   assign linear_reg_monitor_blank = st_reg.blank;
   // one-hot wait bit, taken straight from its flop
   assign seq_gap_busy = st_reg.sq_state[1];
   assign seq_gap_done = st_reg.gap_done;

endmodule

// ---- rtl/pmsr_regs.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the
//          slew, linear regulator and sequencer delay register bank
// Assumes: 50 MHz system clock
// Notes:   all times are kept in their own unit; cycle counts derive from them
`ifndef PMSR_REGS_SVH
`define PMSR_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PMSR_ADDR_SLEW 8'h1a
`define PMSR_ADDR_LDO 8'h1b
`define PMSR_ADDR_SEQ_LO 8'h20
`define PMSR_ADDR_SEQ_HI 8'h21

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define PMSR_GO_BIT 7
`define PMSR_BYPASS_BIT 6
`define PMSR_FACTOR_BIT 7
`define PMSR_GAP9_BIT 0
`define PMSR_SLEW_RST 3'h6
`define PMSR_LDO_RST 6'h1f
`define PMSR_SEQ_LO_RST 8'h00
`define PMSR_SEQ_HI_RST 1'h0
`define PMSR_SLEW_FASTEST 3'h6
`define PMSR_SLEW_IMMEDIATE 3'h7

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PMSR_CLK_PERIOD_NS 20
`define PMSR_SLEW_MIN_STEP_NS 2500
`define PMSR_SLEW_UNIT_CYC (`PMSR_SLEW_MIN_STEP_NS / `PMSR_CLK_PERIOD_NS)
`define PMSR_US_NS 1000
`define PMSR_US_CYC (`PMSR_US_NS / `PMSR_CLK_PERIOD_NS)
`define PMSR_GAP_SHORT_MS 2
`define PMSR_GAP_LONG_MS 5
`define PMSR_BLANK_MS 5
`define PMSR_PD_FACTOR 10
`define PMSR_MS_US 1000

`endif

// ---- rtl/pmsr_pkg.sv ----
// Purpose: types of the slew, linear regulator and sequencer delay bank
// Assumes: constants come from pmsr_regs.svh
// Notes:   one packed struct holds all state of the top module
package pmsr_pkg;

   // ----------------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pmsr_req_t;

   typedef struct packed {
      logic [5:0] one;
      logic [5:0] two;
   } pmsr_buck_t;

   // ----------------------------------------------------------------------
   // states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SL_IDLE = 2'b01,
      SL_MOVE = 2'b10
   } pmsr_slew_st_t;

   typedef enum logic [1:0] {
      SQ_IDLE = 2'b01,
      SQ_WAIT = 2'b10
   } pmsr_seq_st_t;

   typedef struct packed {
      logic go;
      logic trigger_bypass;
      logic [2:0] slew;
      logic [5:0] linear_reg_setpoint;
      logic [7:0] seq_lo;
      logic powerdown_gap_multiplier;
      logic gap_nine_select;
      logic [7:0] rdata;
      logic rvalid;
      logic wr_refused;
      pmsr_slew_st_t sl_state;
      logic [12:0] step_cnt;
      pmsr_buck_t buck;
      logic [5:0] us_cnt;
      logic us_tick;
      logic [15:0] blank_cnt;
      logic blank;
      pmsr_seq_st_t sq_state;
      logic [15:0] gap_cnt;
      logic gap_done;
   } pmsr_state_t;

endpackage

// ---- test/pmsr_chk.sv ----
// Purpose: assertions on the ports of the slew, regulator and delay bank
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every pmsr_top at the foot
`timescale 1ns/10ps
module pmsr_chk import pmsr_pkg::*; #(
   parameter logic [12:0] STEP_UNIT_CYC = 13'h7d,
   parameter logic [5:0] US_CYC = 6'h32
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire pmsr_pkg::pmsr_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic reg_wr_refused,
   input wire logic pw_unlocked,
   input wire pmsr_pkg::pmsr_buck_t buck_target,
   input wire logic buck_target_update,
   input wire pmsr_pkg::pmsr_buck_t buck_code,
   input wire logic buck_busy,
   input wire logic [5:0] linear_reg_setpoint,
   input wire logic linear_reg_monitor_blank,
   input wire logic seq_gap_start,
   input wire logic seq_gap_busy,
   input wire logic seq_gap_done
);
   // ----------------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   logic prot;
   logic go_wr;
   logic [23:0] gcnt_reg;
   assign prot = reg_req.wr && reg_req.addr inside {8'h1b, 8'h20, 8'h21};
   assign go_wr = reg_req.wr && reg_req.addr == 8'h1a;
   // counts busy cycles so the gap length can be judged at done
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         gcnt_reg <= 24'h0;
      end else begin
         gcnt_reg <= seq_gap_busy ? gcnt_reg + 24'h1 : 24'h0;
      end
   end
   refuse_locked_a: assert property (
      prot && !pw_unlocked |=> reg_wr_refused && $stable(linear_reg_setpoint))
      else $error("locked write not refused");
   ldo_write_a: assert property (
      prot && pw_unlocked && reg_req.addr == 8'h1b |=> linear_reg_monitor_blank
      && linear_reg_setpoint == $past(reg_req.wdata[5:0])) else $error("setpoint write lost");
   ldo_read_a: assert property (
      reg_req.rd && reg_req.addr == 8'h1b |=> reg_rvalid
      && reg_rdata == {2'h0, $past(linear_reg_setpoint)}) else $error("setpoint read wrong");
   seq_hi_rsvd_a: assert property (
      reg_req.rd && reg_req.addr == 8'h21 |=> reg_rdata[6:1] == 6'h0)
      else $error("reserved bits set");
   go_busy_a: assert property (
      go_wr && reg_req.wdata[7] |=> buck_busy) else $error("go did not start");
   busy_end_a: assert property (
      buck_busy && buck_code == buck_target && !go_wr && !buck_target_update |=> !buck_busy)
      else $error("busy outlived move");
   code_move_a: assert property (
      $changed(buck_code) |-> $past(buck_busy)) else $error("rail moved while idle");
   gap_busy_a: assert property (
      seq_gap_start && !seq_gap_busy |=> seq_gap_busy [*8]) else $error("gap not started");
   gap_len_a: assert property (
      seq_gap_done |-> gcnt_reg >= 1998 * US_CYC && !seq_gap_busy) else $error("gap too short");
   cover property (buck_busy ##1 !buck_busy);
   cover property (seq_gap_done);
   cover property (reg_wr_refused);
endmodule

bind pmsr_top pmsr_chk #(.STEP_UNIT_CYC(STEP_UNIT_CYC), .US_CYC(US_CYC)) chk (.sys_clk,
   .reset_n, .reg_req, .reg_rdata, .reg_rvalid, .reg_wr_refused, .pw_unlocked, .buck_target,
   .buck_target_update, .buck_code, .buck_busy, .linear_reg_setpoint,
   .linear_reg_monitor_blank, .seq_gap_start, .seq_gap_busy, .seq_gap_done);

// ---- test/pmsr_host.sv ----
// Purpose: host model issuing register cycles over the sub-address port
// Assumes: requests launched just after a rising edge
// Notes: released lines show inverted data, never the last value
`timescale 1ns/10ps
module pmsr_host import pmsr_pkg::*; (
   input wire logic sys_clk,
   output pmsr_pkg::pmsr_req_t reg_req,
   output logic pw_unlocked,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_req = '0;
      pw_unlocked = 1'b0;
   end
   // protected writes only after this is raised
   task automatic unlock(input logic en);
      @(posedge sys_clk);
      #1;
      pw_unlocked = en;
   endtask
   task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_req = {w, !w, a, d};
      @(posedge sys_clk);
      #1;
      reg_req = {2'b00, ~a, ~d};
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      cyc(1'b0, a, 8'h00);
      d = reg_rdata;
   endtask
endmodule

// ---- test/pmsr_top_tb.sv ----
// Purpose: self-checking bench of the slew, regulator and delay bank
// Assumes: timing parameters shortened to 2 cycles
// Notes: fixed seed, corner values mixed into random data
`timescale 1ns/10ps
module pmsr_top_tb;
   import pmsr_pkg::*;
   localparam logic [12:0] STEP = 13'h2;
   localparam logic [5:0] US = 6'h2;
   logic sys_clk = 1'b0, reset_n = 1'b0, buck_target_update = 1'b0, reg_rvalid, reg_wr_refused;
   logic seq_gap_start = 1'b0, seq_powerdown = 1'b0, buck_busy, seq_gap_busy, seq_gap_done;
   logic pw_unlocked, linear_reg_monitor_blank;
   logic [3:0] seq_gap_index = 4'h1;
   logic [5:0] linear_reg_setpoint;
   logic [7:0] reg_rdata, d, r, a;
   logic [2:0] mon;
   pmsr_req_t reg_req;
   pmsr_buck_t buck_target = '0, buck_code, b0;
   int n_errors, num_checks, n, st, p;
   logic [7:0] ra[5] = '{8'h1a, 8'h1b, 8'h20, 8'h21, 8'h30};
   logic [7:0] rv[5] = '{8'h06, 8'h1f, 8'h00, 8'h00, 8'h00};
   logic [2:0] codes[3] = '{3'h6, 3'h0, 3'h7};
   int gi[5] = '{1, 2, 9, 2, 0}, gp[5] = '{0, 0, 0, 1, 0};
   int ge[5] = '{5000, 2000, 5000, 20000, 2000};
   assign mon = {linear_reg_monitor_blank, seq_gap_busy, buck_busy};
   always #10 sys_clk = ~sys_clk;
   pmsr_top #(.STEP_UNIT_CYC(STEP), .US_CYC(US)) dut (.sys_clk, .reset_n, .reg_req, .reg_rdata,
      .reg_rvalid, .reg_wr_refused, .pw_unlocked, .buck_target, .buck_target_update,
      .buck_code, .buck_busy, .linear_reg_setpoint, .linear_reg_monitor_blank, .seq_gap_start,
      .seq_gap_index, .seq_powerdown, .seq_gap_busy, .seq_gap_done);
   pmsr_host host (.sys_clk, .reg_req, .pw_unlocked, .reg_rdata);
   // ----------------------------------------------------------------------
   // checks and helpers
   // ----------------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s got %0h want %0h", $time, what, got, exp);
      end
   endtask
   task automatic chk_rng(input int v, input int lo, input int hi, input string what);
      chk(32'(v >= lo && v <= hi), 32'h1, what);
   endtask
   // bounded wait for one monitored level to fall, counting cycles
   task automatic span(input int sel, output int c);
      c = 0;
      while (mon[sel] === 1'b1) begin
         @(posedge sys_clk);
         #1;
         c++;
         if (c > 50000) begin
            chk(32'h0, 32'h1, "wait expired");
            tally_and_finish();
         end
      end
   endtask
   function automatic int gap(input logic [5:0] x, input logic [5:0] y);
      return x > y ? int'(x - y) : int'(y - x);
   endfunction
   function automatic logic [7:0] mask(input logic [7:0] x);
      return x == 8'h1b ? 8'h3f : x == 8'h21 ? 8'h81 : 8'hff;
   endfunction
   initial begin
      void'($urandom(79));
      repeat (8) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      for (int i = 1; i < 4; i++) begin
         host.wr(ra[i], 8'hff);
         chk(reg_wr_refused, 1'b1, "locked write");
      end
      for (int i = 0; i < 5; i++) begin
         host.rd(ra[i], d);
         chk(d, rv[i], "reset value");
      end
      $display("test reset_and_lock done");
      host.unlock(1'b1);
      for (int i = 0; i < 12; i++) begin
         a = ra[1 + $urandom % 3];
         d = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom);
         host.wr(a, d);
         host.rd(a, r);
         chk(r, d & mask(a), "readback");
      end
      host.wr(8'h1b, 8'h2a);
      span(2, n);
      chk_rng(n, 4998 * US, 5002 * US, "blanking");
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         buck_target = pmsr_buck_t'(12'($urandom));
         b0 = buck_code;
         st = gap(b0.one, buck_target.one) > gap(b0.two, buck_target.two) ?
            gap(b0.one, buck_target.one) : gap(b0.two, buck_target.two);
         p = codes[i] == 3'h7 ? 0 : int'(STEP) << (6 - codes[i]);
         host.wr(8'h1a, {5'h10, codes[i]});
         chk(buck_busy, 1'b1, "busy");
         span(0, n);
         chk_rng(n, st * p, st * p + p + 4, "slew time");
         chk(buck_code, buck_target, "rails");
         host.rd(8'h1a, r);
         chk(r, {5'h0, codes[i]}, "go clear");
      end
      host.wr(8'h1a, 8'h47);
      @(posedge sys_clk);
      #1;
      buck_target = pmsr_buck_t'(12'($urandom));
      buck_target_update = 1'b1;
      @(posedge sys_clk);
      #1;
      buck_target_update = 1'b0;
      span(0, n);
      chk(buck_code, buck_target, "bypass move");
      $display("test slew done");
      host.wr(8'h20, 8'h01);
      host.wr(8'h21, 8'h81);
      for (int i = 0; i < 5; i++) begin
         seq_gap_index = 4'(gi[i]);
         seq_powerdown = gp[i][0];
         seq_gap_start = 1'b1;
         @(posedge sys_clk);
         #1;
         seq_gap_start = 1'b0;
         span(1, n);
         chk(seq_gap_done, 1'b1, "gap done");
         chk_rng(n, (ge[i] - 2) * US, (ge[i] + 2) * US, "gap time");
      end
      $display("test gaps done");
      tally_and_finish();
   end
endmodule
